// ===== bench/cedg_can_bus.sv
// Behavioural CAN bus behind the transceiver: our node and one peer.
// Assumes 0 is dominant; termination pulls a released bus recessive.
`timescale 1ns/1ps
`default_nettype none
module cedg_can_bus (
  // Node pins
  input wire logic tx_pin_in,
  output logic rx_pin_out,
  // Peer drive, 0 = dominant
  input wire logic peer_level_in
);
  // Dominant wins, so no stale level survives a release
  assign rx_pin_out = tx_pin_in & peer_level_in;
endmodule // cedg_can_bus
`default_nettype wire

// ===== bench/cedg_top_asserts.sv
// Port-level checker for the CAN error, diagnostic and time-stamp block.
// Assumes it is bound onto cedg_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "cedg_params.svh"
module cedg_top_asserts (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Pins and engine
  input wire logic receive_pin_in,
  input wire logic transmit_pin_out,
  input wire cedg_pkg::cedg_frame_evt_t frame_evt_in,
  input wire cedg_pkg::cedg_tx_req_t tx_req_in,
  input wire cedg_pkg::cedg_xfer_t xfer_in,
  input wire logic rx_level_out,
  input wire logic can_enable_out,
  input wire logic ts_wr_out,
  input wire logic [3:0] ts_buf_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);
  logic mapped;
  logic drives;
  assign mapped = paddr_in inside {`CEDG_OFS_GLOBAL_CFG, `CEDG_OFS_ERROR_COUNTS,
    `CEDG_OFS_LAST_ERR_DIAG, `CEDG_OFS_BIT_TIME_CNT, `CEDG_OFS_ERR_IRQ};
  assign drives = frame_evt_in.is_tx || tx_req_in.ack_slot || tx_req_in.err_flag;
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_answer;
    pready_out ##1 !pready_out;
  endsequence
  property p_ready;
    s_setup |=> s_answer;
  endproperty
  a_ready: assert property (p_ready) else $error("pready not one cycle after setup");
  property p_unmapped;
    s_setup ##0 !mapped |=> pslverr_out && prdata_out == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_counts_high;
    s_setup ##0 paddr_in == `CEDG_OFS_ERROR_COUNTS |=> prdata_out[31:16] == 16'h0000;
  endproperty
  a_counts_high: assert property (p_counts_high) else $error("counts upper half set");
  property p_diag_high;
    s_setup ##0 paddr_in == `CEDG_OFS_LAST_ERR_DIAG |=> prdata_out[31:15] == 17'h0_0000;
  endproperty
  a_diag_high: assert property (p_diag_high) else $error("diag reserved bits set");
  property p_rx_off;
    !can_enable_out [*2] |-> rx_level_out;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx passed while disabled");
  property p_rx_on;
    can_enable_out [*2] |-> rx_level_out == $past(receive_pin_in);
  endproperty
  a_rx_on: assert property (p_rx_on) else $error("rx not passed while enabled");
  // Enable output lags the internal enable by one cycle, so it is read one cycle on
  property p_tx_quiet;
    !drives || !can_enable_out ##1 !can_enable_out |-> transmit_pin_out;
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("bus driven outside slots");
  property p_tx_drive;
    can_enable_out && drives ##1 can_enable_out |-> transmit_pin_out == $past(tx_req_in.level);
  endproperty
  a_tx_drive: assert property (p_tx_drive) else $error("tx level not driven");
  property p_ts_wr;
    xfer_in.done |=> ts_wr_out && ts_buf_out == $past(xfer_in.buf_idx);
  endproperty
  a_ts_wr: assert property (p_ts_wr) else $error("stamp write missing");
  property p_ts_cause;
    ts_wr_out |-> $past(xfer_in.done);
  endproperty
  a_ts_cause: assert property (p_ts_cause) else $error("stamp write without transfer");
endmodule // cedg_top_asserts
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for cedg_top over APB with a wired-AND bus model.
// Assumes the design, the checker and the bus model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "cedg_params.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
  localparam logic [11:0] CFG = `CEDG_OFS_GLOBAL_CFG;
  localparam logic [11:0] EC = `CEDG_OFS_ERROR_COUNTS;
  localparam logic [11:0] DG = `CEDG_OFS_LAST_ERR_DIAG;
  localparam logic [11:0] TMR = `CEDG_OFS_BIT_TIME_CNT;
  localparam logic [11:0] IRQ = `CEDG_OFS_ERR_IRQ;
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic peer = 1'b1;
  logic perr;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, transmit_pin_out, rx_level_out;
  logic can_enable_out, ts_wr_out, error_irq_out;
  wire logic receive_pin_in;
  logic [3:0] ts_buf_out;
  logic [15:0] ts_value_out;
  cedg_pkg::cedg_fc_evt_t fc_evt_in = '0;
  cedg_pkg::cedg_frame_evt_t frame_evt_in = '0;
  cedg_pkg::cedg_tx_req_t tx_req_in = '0;
  cedg_pkg::cedg_xfer_t xfer_in = '0;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  cedg_top cedg_top_i (.*);
  cedg_can_bus cedg_can_bus_i (.tx_pin_in(transmit_pin_out), .rx_pin_out(receive_pin_in),
    .peer_level_in(peer));
  initial begin
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  task give_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      give_verdict();
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    q = prdata_out;
    perr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task rd(input logic [11:0] a, input logic [15:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    `CHK(q, {16'h0000, e})
  endtask
  task fc_p(input logic [4:0] v);
    fc_evt_in <= v;
    @(posedge clk_sys_in);
    fc_evt_in <= '0;
    @(posedge clk_sys_in);
  endtask
  // Pulse fields drop after one cycle; the is_tx transmitter flag stays
  task fe_p(input logic [15:0] v);
    frame_evt_in <= v;
    @(posedge clk_sys_in);
    frame_evt_in <= {15'h0000, v[0]};
    @(posedge clk_sys_in);
  endtask
  task xf(input logic [3:0] b, input logic [15:0] e);
    xfer_in <= {1'b1, b};
    @(posedge clk_sys_in);
    xfer_in <= '0;
    @(negedge clk_sys_in);
    `CHK({ts_wr_out, ts_buf_out, ts_value_out}, {1'b1, b, e})
    @(posedge clk_sys_in);
  endtask
  initial begin
    logic [4:0] ev [5];
    logic [15:0] ex [5];
    ev = '{5'h04, 5'h10, 5'h08, 5'h02, 5'h01};
    ex = '{16'h0008, 16'h0108, 16'h0908, 16'h0907, 16'h0807};
    repeat (5) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    rd(EC, 16'h0000);
    rd(DG, 16'h0000);
    rd(TMR, 16'h0000);
    rd(12'h014, 16'h0000);
    `CHK(perr, 1'b1)
    wr(CFG, 32'h0000_0003);
    repeat (5) fe_p(16'h8000);
    rd(TMR, 16'h0005);
    xf(4'h3, 16'h0005);
    xf(4'h0, 16'h0005);
    rd(TMR, 16'h0000);
    fe_p(16'h8000);
    wr(CFG, 32'h0000_0001);
    xf(4'h0, 16'h0001);
    rd(TMR, 16'h0001);
    wr(CFG, 32'h0000_0005);
    for (int i = 0; i < 5; i++) begin
      fc_p(ev[i]);
      rd(EC, ex[i]);
    end
    rd(IRQ, 16'h0001);
    `CHK(error_irq_out, 1'b1)
    wr(IRQ, 32'h0000_0001);
    rd(IRQ, 16'h0000);
    `CHK(error_irq_out, 1'b0)
    wr(CFG, 32'h0000_0001);
    fc_p(5'h04);
    rd(EC, 16'h080F);
    rd(IRQ, 16'h0001);
    `CHK(error_irq_out, 1'b0)
    for (int c = 0; c < 16; c++) begin
      fe_p({2'h1, c[3:0], 6'h01, 4'h0});
      fe_p(16'h0008);
      rd(DG, {12'h600, c[3:0]});
    end
    fe_p({2'h1, 4'hE, 6'h08, 4'h1});
    repeat (3) fe_p(16'h8001);
    fe_p(16'h000D);
    rd(DG, 16'h0C4E);
    tx_req_in <= 3'h2;
    fe_p({2'h1, 4'h4, 6'h02, 4'h0});
    fe_p(16'h000A);
    rd(DG, 16'h1014);
    tx_req_in <= 3'h4;
    wr(DG, 32'hFFFF_FFFF);
    wr(EC, 32'hFFFF_FFFF);
    rd(DG, 16'h1014);
    rd(EC, 16'h080F);
    // Engine quiet, error pending flag still set, before the enable is cleared
    wr(CFG, 32'h0000_0006);
    // Falling edge on the line is what an outside wake-up channel would see
    peer <= 1'b0;
    rd(CFG, 16'h0006);
    `CHK(rx_level_out, 1'b1)
    `CHK(can_enable_out, 1'b0)
    give_verdict();
  end
endmodule // tb
bind cedg_top cedg_top_asserts cedg_top_asserts_i (.*);
`default_nettype wire

// ===== hw/cedg_diag.sv
// Bit position tracking and capture of the last error diagnostic word.
// Assumes field_start and bit_tick come from the bit stream logic of the engine.
`timescale 1ns/1ps
`default_nettype none
`include "cedg_params.svh"

module cedg_diag (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Frame events and pin levels
  input wire cedg_pkg::cedg_frame_evt_t evt_in,
  input wire logic rx_level_in,
  input wire logic tx_level_in,
  // Captured word
  output logic [15:0] diag_out
);

  logic [3:0] field_r;
  logic [5:0] pos_r;
  logic [15:0] diag_r;

  // Field length minus one loaded, then one step down per CAN bit
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      field_r <= 4'h0;
      pos_r <= 6'h00;
    end else if (evt_in.field_start) begin
      field_r <= evt_in.field_code;
      pos_r <= evt_in.field_len - 6'h01;
    end else if (evt_in.bit_tick) begin
      pos_r <= pos_r - 6'h01;
    end
  end

  // Whole word replaced at once so fields never mix two errors
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      diag_r <= `CEDG_DG_RESET;
    end else if (evt_in.err_det) begin
      diag_r <= '0;
      diag_r[`CEDG_DG_FIELD_MSB:`CEDG_DG_FIELD_LSB] <= field_r;
      diag_r[`CEDG_DG_POS_MSB:`CEDG_DG_POS_LSB] <= pos_r;
      diag_r[`CEDG_DG_TX_BIT] <= evt_in.is_tx;
      diag_r[`CEDG_DG_STUFF_BIT] <= evt_in.err_stuff;
      diag_r[`CEDG_DG_CRC_BIT] <= evt_in.err_crc;
      diag_r[`CEDG_DG_MON_BIT] <= rx_level_in;
      diag_r[`CEDG_DG_DRIVE_BIT] <= tx_level_in;
    end
  end

  assign diag_out = diag_r;

endmodule // cedg_diag

`default_nettype wire

// ===== hw/cedg_err_counter.sv
// Receive and transmit error counters with change pulse.
// Assumes at most one fault-confinement event class per cycle from the engine.
`timescale 1ns/1ps
`default_nettype none
`include "cedg_params.svh"

module cedg_err_counter (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Events
  input wire cedg_pkg::cedg_fc_evt_t evt_in,
  // Counts
  output logic [7:0] rec_out,
  output logic [7:0] tec_out,
  output logic changed_out
);

  logic [7:0] rec_r;
  logic [7:0] rec_nxt;
  logic [7:0] tec_r;
  logic [7:0] tec_nxt;

  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[8] ? `CEDG_FC_MAX : s[7:0];
  endfunction

  // Standard fault confinement, saturating at the 8-bit limit
  always_comb begin
    rec_nxt = rec_r;
    tec_nxt = tec_r;
    if (evt_in.rx_err_large) begin
      rec_nxt = sat_add(rec_r, `CEDG_FC_STEP_LARGE);
    end else if (evt_in.rx_err) begin
      rec_nxt = sat_add(rec_r, `CEDG_FC_STEP_SMALL);
    end else if (evt_in.rx_ok) begin
      if (rec_r > `CEDG_FC_PASSIVE_LIMIT) begin
        rec_nxt = `CEDG_FC_REC_RELOAD;
      end else if (rec_r != 8'h00) begin
        rec_nxt = rec_r - `CEDG_FC_STEP_SMALL;
      end
    end
    if (evt_in.tx_err) begin
      tec_nxt = sat_add(tec_r, `CEDG_FC_STEP_LARGE);
    end else if (evt_in.tx_ok && tec_r != 8'h00) begin
      tec_nxt = tec_r - `CEDG_FC_STEP_SMALL;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rec_r <= 8'h00;
      tec_r <= 8'h00;
      changed_out <= 1'b0;
    end else begin
      rec_r <= rec_nxt;
      tec_r <= tec_nxt;
      changed_out <= (rec_nxt != rec_r) || (tec_nxt != tec_r);
    end
  end

  assign rec_out = rec_r;
  assign tec_out = tec_r;

endmodule // cedg_err_counter

`default_nettype wire

// ===== hw/cedg_params.svh
// Offsets, field positions, reset values and counts for the CAN error/diag/time-stamp block.
// Assumes a 32-bit APB register bus with one aligned word per register.
`ifndef CEDG_PARAMS_SVH
`define CEDG_PARAMS_SVH

// Register byte offsets
`define CEDG_OFS_GLOBAL_CFG 12'h000
`define CEDG_OFS_ERROR_COUNTS 12'h004
`define CEDG_OFS_LAST_ERR_DIAG 12'h008
`define CEDG_OFS_BIT_TIME_CNT 12'h00C
`define CEDG_OFS_ERR_IRQ 12'h010

// Global configuration fields
`define CEDG_CFG_ENABLE_BIT 0
`define CEDG_CFG_TSTAMP_BIT 1
`define CEDG_CFG_IRQ_EN_BIT 2
`define CEDG_CFG_WIDTH 3
`define CEDG_CFG_RESET 3'h0

// Error irq status field
`define CEDG_IRQ_PEND_BIT 0

// Error counts layout
`define CEDG_EC_REC_MSB 15
`define CEDG_EC_REC_LSB 8
`define CEDG_EC_TEC_MSB 7
`define CEDG_EC_TEC_LSB 0
`define CEDG_EC_RESET 16'h0000

// Diagnostic layout
`define CEDG_DG_FIELD_MSB 3
`define CEDG_DG_FIELD_LSB 0
`define CEDG_DG_POS_MSB 9
`define CEDG_DG_POS_LSB 4
`define CEDG_DG_TX_BIT 10
`define CEDG_DG_STUFF_BIT 11
`define CEDG_DG_CRC_BIT 12
`define CEDG_DG_MON_BIT 13
`define CEDG_DG_DRIVE_BIT 14
`define CEDG_DG_RESET 16'h0000

// Bit-time counter
`define CEDG_TMR_RESET 16'h0000

// Fault confinement steps
`define CEDG_FC_STEP_SMALL 8'h01
`define CEDG_FC_STEP_LARGE 8'h08
`define CEDG_FC_PASSIVE_LIMIT 8'h7F
`define CEDG_FC_REC_RELOAD 8'h78
`define CEDG_FC_MAX 8'hFF

// Buffer that restarts the time stamp
`define CEDG_TS_RESTART_BUF 4'h0

`endif

// ===== hw/cedg_pkg.sv
// Types shared by the CAN error/diag/time-stamp block.
// Assumes the protocol engine delivers one-cycle event pulses on clk_sys_in.
package cedg_pkg;

  // Fault-confinement events from the protocol engine
  typedef struct packed {
    logic rx_err;
    logic rx_err_large;
    logic tx_err;
    logic tx_ok;
    logic rx_ok;
  } cedg_fc_evt_t;

  // Field tracking and error detection from the protocol engine
  typedef struct packed {
    logic bit_tick;
    logic field_start;
    logic [3:0] field_code;
    logic [5:0] field_len;
    logic err_det;
    logic err_stuff;
    logic err_crc;
    logic is_tx;
  } cedg_frame_evt_t;

  // Transmit request from the protocol engine
  typedef struct packed {
    logic level;
    logic ack_slot;
    logic err_flag;
  } cedg_tx_req_t;

  // Completed transfer of one message buffer
  typedef struct packed {
    logic done;
    logic [3:0] buf_idx;
  } cedg_xfer_t;

  typedef enum logic [1:0] {
    CEDG_APB_IDLE = 2'b00,
    CEDG_APB_ACCESS = 2'b01
  } cedg_apb_st_t;

endpackage

// ===== hw/cedg_top.sv
// CAN error counters, last-error diagnostic, bit-time counter and pin gating, APB slave.
// Assumes an APB master on clk_sys_in and a protocol engine issuing one-cycle pulses.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cedg_params.svh"

// Function
// - Error counts read-only: receive count high byte, transmit low byte, zero at reset.
// - Diagnostic register holds last error, read-only, cleared on reset.
// - Bits 3..0 encode the frame field where the last error happened.
// - Bits 9..4 load field length minus one, count down per bit.
// - Bit 10 set when we were transmitter at the error.
// - Bit 11 set when a stuffing violation caused the error.
// - Bit 12 set when received CRC was invalid; valid with ACK code.
// - Bit 13 records sampled receive pin level at the error.
// - Bit 14 records driven transmit pin level at the error.
// - As receiver, drive dominant only in ACK slot and active error flag.
// - Free-running 16-bit read-only bit counter, one step per CAN bit.
// - With time stamp enabled, buffer 0 transfer restarts the bit counter.
// - Each good frame copies the bit counter into its buffer's stamp.
// - Clearing enable also shuts the receive pin off.
// - Configuration survives a disabled power-down; only reset clears it.
// - Any error count change sets the pending flag; enable gates interrupt.
module cedg_top (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // CAN pins
  input wire logic receive_pin_in,
  output logic transmit_pin_out,
  // Protocol engine side
  input wire cedg_pkg::cedg_fc_evt_t fc_evt_in,
  input wire cedg_pkg::cedg_frame_evt_t frame_evt_in,
  input wire cedg_pkg::cedg_tx_req_t tx_req_in,
  input wire cedg_pkg::cedg_xfer_t xfer_in,
  output logic rx_level_out,
  output logic can_enable_out,
  // Time stamp write to message buffer
  output logic ts_wr_out,
  output logic [3:0] ts_buf_out,
  output logic [15:0] ts_value_out,
  // Error interrupt request
  output logic error_irq_out
);

  cedg_pkg::cedg_apb_st_t apb_st_r;
  logic [`CEDG_CFG_WIDTH-1:0] global_configuration_r;
  logic error_irq_pending_r;
  logic [15:0] bit_time_counter_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;
  logic pready_r;
  logic pslverr_r;
  logic hit_nxt;
  logic setup_phase;
  logic wr_done;
  logic rx_level_r;
  logic transmit_pin_r;
  logic ts_wr_r;
  logic [3:0] ts_buf_r;
  logic [15:0] ts_value_r;
  logic irq_r;
  logic [7:0] receive_error_count;
  logic [7:0] transmit_error_count;
  logic counts_changed;
  logic [15:0] error_counts;
  logic [15:0] last_error_diagnostic;
  logic can_enable;
  logic time_stamp_enable;
  logic error_irq_enable;
  logic tx_may_drive;

  assign can_enable = global_configuration_r[`CEDG_CFG_ENABLE_BIT];
  assign time_stamp_enable = global_configuration_r[`CEDG_CFG_TSTAMP_BIT];
  assign error_irq_enable = global_configuration_r[`CEDG_CFG_IRQ_EN_BIT];

  // Counters and diagnostics
  cedg_err_counter u_err_counter (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .evt_in(fc_evt_in),
    .rec_out(receive_error_count),
    .tec_out(transmit_error_count),
    .changed_out(counts_changed)
  );

  assign error_counts = {receive_error_count, transmit_error_count};

  cedg_diag u_diag (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .evt_in(frame_evt_in),
    .rx_level_in(rx_level_r),
    .tx_level_in(transmit_pin_r),
    .diag_out(last_error_diagnostic)
  );

  // APB: no wait state; read data is registered at the end of the setup phase
  assign setup_phase = psel_in && !penable_in;
  assign wr_done = psel_in && penable_in && pready_r && pwrite_in;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    hit_nxt = 1'b1;
    if (paddr_in == `CEDG_OFS_GLOBAL_CFG) begin
      rd_nxt[`CEDG_CFG_WIDTH-1:0] = global_configuration_r;
    end else if (paddr_in == `CEDG_OFS_ERROR_COUNTS) begin
      rd_nxt[15:0] = error_counts;
    end else if (paddr_in == `CEDG_OFS_LAST_ERR_DIAG) begin
      rd_nxt[15:0] = last_error_diagnostic;
    end else if (paddr_in == `CEDG_OFS_BIT_TIME_CNT) begin
      rd_nxt[15:0] = bit_time_counter_r;
    end else if (paddr_in == `CEDG_OFS_ERR_IRQ) begin
      rd_nxt[`CEDG_IRQ_PEND_BIT] = error_irq_pending_r;
    end else begin
      hit_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      apb_st_r <= cedg_pkg::CEDG_APB_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      case (apb_st_r)
        cedg_pkg::CEDG_APB_IDLE: begin
          if (setup_phase) begin
            apb_st_r <= cedg_pkg::CEDG_APB_ACCESS;
            pready_r <= 1'b1;
            pslverr_r <= !hit_nxt;
            prdata_r <= pwrite_in ? 32'h0000_0000 : rd_nxt;
          end
        end
        cedg_pkg::CEDG_APB_ACCESS: begin
          apb_st_r <= cedg_pkg::CEDG_APB_IDLE;
          pready_r <= 1'b0;
          pslverr_r <= 1'b0;
          prdata_r <= 32'h0000_0000;
        end
        default: begin
          apb_st_r <= cedg_pkg::CEDG_APB_IDLE;
          pready_r <= 1'b0;
        end
      endcase
    end
  end

  // Configuration cleared only by reset, so disable and power-down keep it
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      global_configuration_r <= `CEDG_CFG_RESET;
    end else if (wr_done && paddr_in == `CEDG_OFS_GLOBAL_CFG) begin
      global_configuration_r <= pwdata_in[`CEDG_CFG_WIDTH-1:0];
    end
  end

  // Pending flag: a count change in the clearing cycle wins over the clear
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      error_irq_pending_r <= 1'b0;
    end else if (counts_changed) begin
      error_irq_pending_r <= 1'b1;
    end else if (wr_done && paddr_in == `CEDG_OFS_ERR_IRQ && pwdata_in[`CEDG_IRQ_PEND_BIT]) begin
      error_irq_pending_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= error_irq_pending_r && error_irq_enable;
    end
  end

  // Bit-time counter; restart takes priority over the step
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bit_time_counter_r <= `CEDG_TMR_RESET;
    end else if (time_stamp_enable && xfer_in.done
                 && xfer_in.buf_idx == `CEDG_TS_RESTART_BUF) begin
      bit_time_counter_r <= `CEDG_TMR_RESET;
    end else if (frame_evt_in.bit_tick) begin
      bit_time_counter_r <= bit_time_counter_r + 16'h0001;
    end
  end

  // Stamp captured before any restart of the same cycle
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ts_wr_r <= 1'b0;
      ts_buf_r <= 4'h0;
      ts_value_r <= 16'h0000;
    end else begin
      ts_wr_r <= xfer_in.done;
      if (xfer_in.done) begin
        ts_buf_r <= xfer_in.buf_idx;
        ts_value_r <= bit_time_counter_r;
      end
    end
  end

  // Pins: disabled controller sees recessive and drives recessive
  assign tx_may_drive = frame_evt_in.is_tx || tx_req_in.ack_slot || tx_req_in.err_flag;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_level_r <= 1'b1;
      transmit_pin_r <= 1'b1;
    end else begin
      rx_level_r <= can_enable ? receive_pin_in : 1'b1;
      transmit_pin_r <= (can_enable && tx_may_drive) ? tx_req_in.level : 1'b1;
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign transmit_pin_out = transmit_pin_r;
  assign rx_level_out = rx_level_r;
  assign ts_wr_out = ts_wr_r;
  assign ts_buf_out = ts_buf_r;
  assign ts_value_out = ts_value_r;
  assign error_irq_out = irq_r;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      can_enable_out <= 1'b0;
    end else begin
      can_enable_out <= can_enable;
    end
  end

endmodule // cedg_top

`default_nettype wire
